// >>> common/usdp_defines.vh
/*
 * constants for the serial port transmit/receive data path: register
 * offsets, field positions, size codes and timing figures.
 * assumes a 50 MHz core clock and an 8-bit register port.
 */
`ifndef USDP_DEFINES_VH
`define USDP_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define USDP_ADDR_DATA      3'h0
`define USDP_ADDR_STAT      3'h1
`define USDP_ADDR_CTRL      3'h2
`define USDP_ADDR_FMT       3'h3
`define USDP_ADDR_BAUDL     3'h4
`define USDP_ADDR_BAUDH     3'h5

// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define USDP_ST_RXC         7
`define USDP_ST_TXC         6
`define USDP_ST_TX_BUFFER_EMPTY_FLAG        5
`define USDP_ST_U2X         1

// ----------------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------------
`define USDP_CT_TX_EMPTY_IRQ_ENABLE       5
`define USDP_CT_TX_COMPLETE_IRQ_ENABLE       6
`define USDP_CT_RECEIVER_ENABLE        4
`define USDP_CT_TRANSMITTER_ENABLE        3
`define USDP_CT_SZ2         2
`define USDP_CT_RX_NINTH_BIT        1
`define USDP_CT_TX_NINTH_BIT        0

// ----------------------------------------------------------------------
// format register bits
// ----------------------------------------------------------------------
`define USDP_FM_SYNC        6
`define USDP_FM_PEN         5
`define USDP_FM_PODD        4
`define USDP_FM_STOP2       3
`define USDP_FM_SZ_HI       2
`define USDP_FM_SZ_LO       1
`define USDP_FM_POL         0

// ----------------------------------------------------------------------
// character size codes and reset values
// ----------------------------------------------------------------------
`define USDP_SZ_5           3'h0
`define USDP_SZ_6           3'h1
`define USDP_SZ_7           3'h2
`define USDP_SZ_8           3'h3
`define USDP_SZ_9           3'h7
`define USDP_FMT_RST        8'h06
`define USDP_ZERO8          8'h00
`define USDP_ZERO12         12'h000
`define USDP_ZERO4          4'h0
`define USDP_ONE4           4'h1

// ----------------------------------------------------------------------
// oversampling
// ----------------------------------------------------------------------
`define USDP_OVS_NORM       4'hF
`define USDP_OVS_DBL        4'h7
`define USDP_MID_NORM       4'h7
`define USDP_MID_DBL        4'h3

`endif

// >>> rtl/usdp_core.v
/*
 * serial port transmit and receive data path with its register port.
 * assumes a one-cycle register port (read data a cycle after the read
 * strobe) and that serial in and the sync clock pin are asynchronous.
 */
// Summary of operation
// (R1) tx enable drives serial out pin
// (R2) sync mode: tx timed by sync clock
// (R3) data write loads buffer, starts send
// (R4) buffer moves to shifter when idle
// (R5) shifter sends one whole frame
// (R6) tx ignores bits above char size
// (R7) ninth tx bit from tx_ninth_bit
// (R8) empty flag shows buffer empty
// (R9) empty irq follows flag while enabled
// (R10) complete flag when frame and buffer done
// (R11) complete flag cleared by service/write-one
// (R12) complete irq when flag sets
// (R13) parity inserted before first stop
// (R14) tx disable waits until all empty
// (R15) rx enable takes serial in pin
// (R16) sync mode: rx clocked by sync clock
// (R17) start bit begins reception, shift bits
// (R18) second stop bit ignored by receiver
// (R19) first stop moves char to buffer
// (R20) rx reads zero above char size
// (R21) software writes zero to empty flag
// (R22) software configures before transmitting
// (R23) frame: start, data lsb first, stops
// (R24) parity is xor, inverted for odd
// (R25) rx flag set; rx disable flushes
// (R26) ninth rx bit read before data
// (R27) idle enabled line stays high
// (R28) one data location, two directions
`include "usdp_defines.vh"

module usdp_core (
    input  wire       core_clk,    // system clock, 50 MHz
    input  wire       rst_n,       // async reset, active low
    input  wire [2:0] reg_addr,    // register address
    input  wire [7:0] reg_wdata,   // write data
    input  wire       reg_wr,      // write strobe
    input  wire       reg_rd,      // read strobe
    output reg  [7:0] reg_rdata,   // read data, cycle after strobe
    input  wire       txc_irq_ack, // tx complete interrupt serviced
    output reg        tx_buffer_empty_flag_irq,    // buffer empty interrupt request
    output reg        txc_irq,     // transmit complete interrupt request
    output reg        txd_o,       // serial out level
    output reg        txd_oe,      // serial out owned by port
    input  wire       rxd_i,       // serial in pin
    output reg        rxd_own,     // serial in owned by port
    input  wire       xck_i,       // sync clock pin input
    output reg        xck_o,       // sync clock pin output level
    output reg        xck_oe       // sync clock pin driven (master)
);

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg        tx_en_ff, rx_en_ff, tx_empty_irq_enable_ff, tx_complete_irq_enable_ff, tx_ninth_bit_ff, u2x_ff;
reg [7:0]  fmt_ff;
reg [11:0] baud_ff;
reg [8:0]  txbuf_ff;
reg        txfull_ff, txc_ff, txact_ff;
reg [11:0] txsh_ff;
reg [3:0]  txcnt_ff;
reg [8:0]  rxbuf_ff;
reg        rxc_ff;
// receive shifter fills from the top, so the oldest bit sits rx_len below bit 10
wire [9:0] rx_algn;
reg        sz2_ff;
wire [2:0] sz_code = {sz2_ff, fmt_ff[`USDP_FM_SZ_HI], fmt_ff[`USDP_FM_SZ_LO]};
wire       sync_m  = fmt_ff[`USDP_FM_SYNC];
wire [3:0] nbits   = (sz_code == `USDP_SZ_9) ? 4'h9 : {2'b01, sz_code[1:0]} + 4'h1;
wire       wr_data = reg_wr && (reg_addr == `USDP_ADDR_DATA);
wire       rd_data = reg_rd && (reg_addr == `USDP_ADDR_DATA);
wire       wr_stat = reg_wr && (reg_addr == `USDP_ADDR_STAT);
wire       wr_ctrl = reg_wr && (reg_addr == `USDP_ADDR_CTRL);

// ----------------------------------------------------------------------
// pin synchronisers: three stages, second and third must agree
// ----------------------------------------------------------------------
reg [2:0] rxs_ff, xcs_ff;
reg       rx_q_ff, xc_q_ff;
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rxs_ff  <= 3'h7;
        xcs_ff  <= 3'h0;
        rx_q_ff <= 1'b1;
        xc_q_ff <= 1'b0;
    end
    else
    begin
        rxs_ff <= {rxs_ff[1:0], rxd_i};
        xcs_ff <= {xcs_ff[1:0], xck_i};
        if (rxs_ff[1] == rxs_ff[2])
            rx_q_ff <= rxs_ff[2];
        if (xcs_ff[1] == xcs_ff[2])
            xc_q_ff <= xcs_ff[2];
    end
end

// ----------------------------------------------------------------------
// baud generator and sync clock edges
// ----------------------------------------------------------------------
// one bit tick per oversample wrap; sync mode uses external clock edges
reg [11:0] bcnt_ff;
reg [3:0]  ovs_ff;
reg        xc_d_ff;
wire       btick   = (bcnt_ff == `USDP_ZERO12);
wire [3:0] ovs_top = u2x_ff ? `USDP_OVS_DBL : `USDP_OVS_NORM;
wire [3:0] ovs_mid = u2x_ff ? `USDP_MID_DBL : `USDP_MID_NORM;
wire       pol     = fmt_ff[`USDP_FM_POL];
wire       xrise   = xc_q_ff && !xc_d_ff;
wire       xfall   = !xc_q_ff && xc_d_ff;
// edge that changes data and edge that samples data
wire       xchg    = pol ? xfall : xrise;
wire       xsmp    = pol ? xrise : xfall;
wire       tx_tick = sync_m ? xchg : (btick && ovs_ff == `USDP_ZERO4); // [R2] [R5]
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        bcnt_ff <= `USDP_ZERO12;
        ovs_ff  <= `USDP_ZERO4;
        xc_d_ff <= 1'b0;
        xck_o   <= 1'b0;
        xck_oe  <= 1'b0;
    end
    else
    begin
        xc_d_ff <= xc_q_ff;
        bcnt_ff <= btick ? baud_ff : bcnt_ff - 12'h001;
        if (btick)
            ovs_ff <= (ovs_ff == `USDP_ZERO4) ? ovs_top : ovs_ff - `USDP_ONE4;
        // this block is always the sync slave: the pin is an input
        xck_oe <= 1'b0;
        xck_o  <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------------
wire [8:0] tx_mask = (9'h1FF >> (4'h9 - nbits));
wire       tx_par  = ^(txbuf_ff & tx_mask) ^ fmt_ff[`USDP_FM_PODD]; // [R24]
// load only on a bit tick so the start bit lasts a whole bit time
wire       tx_load = txfull_ff && tx_tick && (!txact_ff || txcnt_ff == `USDP_ZERO4); // [R4]
wire       tx_done = txact_ff && tx_tick && txcnt_ff == `USDP_ZERO4;
wire [3:0] tx_len  = nbits + {3'h0, fmt_ff[`USDP_FM_PEN]} + {3'h0, fmt_ff[`USDP_FM_STOP2]};
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        txbuf_ff  <= 9'h000;
        txfull_ff <= 1'b0;
        txact_ff  <= 1'b0;
        txsh_ff   <= 12'hFFF;
        txcnt_ff  <= `USDP_ZERO4;
        txc_ff    <= 1'b0;
        txd_o     <= 1'b1;
        txd_oe    <= 1'b0;
    end
    else
    begin
        if (wr_data && tx_en_ff)
        begin
            txbuf_ff  <= {tx_ninth_bit_ff, reg_wdata} & tx_mask; // [R3] [R6] [R7]
            txfull_ff <= 1'b1;                           // [R8]
        end
        else if (tx_load)
            txfull_ff <= 1'b0;                           // [R4]
        if (tx_load)
        begin
            // shifter holds data lsb first, parity, then stop ones
            if (fmt_ff[`USDP_FM_PEN])                    // [R13]
                txsh_ff <= ({3'h7, txbuf_ff} | ~{3'h0, tx_mask}) &
                           ~({11'h000, !tx_par} << nbits);
            else
                txsh_ff <= {3'h7, txbuf_ff} | ~{3'h0, tx_mask};
            txcnt_ff <= tx_len + 4'h1;                   // start plus rest [R23]
            txact_ff <= 1'b1;
            txd_o    <= 1'b0;                            // start bit
        end
        else if (txact_ff && tx_tick)
        begin
            txd_o    <= (txcnt_ff == `USDP_ZERO4) ? 1'b1 : txsh_ff[0]; // [R5]
            txsh_ff  <= {1'b1, txsh_ff[11:1]};
            txcnt_ff <= txcnt_ff - `USDP_ONE4;
            if (tx_done)
                txact_ff <= 1'b0;
        end
        else if (!txact_ff)
            txd_o <= 1'b1;                               // [R27]
        // set wins over clear
        if (tx_done && !txfull_ff)
            txc_ff <= 1'b1;                              // [R10]
        else if (txc_irq_ack || (wr_stat && reg_wdata[`USDP_ST_TXC]))
            txc_ff <= 1'b0;                              // [R11]
        // pin stays owned until buffer and shifter have drained
        txd_oe <= tx_en_ff || txact_ff || txfull_ff;     // [R1] [R14]
    end
end

// ----------------------------------------------------------------------
// receiver
// ----------------------------------------------------------------------
reg [1:0] rst_ff;
reg [3:0] rph_ff, rcnt_ff;
reg [9:0] rxsh_ff;
localparam RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h2;
wire rx_on    = rx_en_ff;                                // [R15]
wire rx_samp  = sync_m ? xsmp : (btick && rph_ff == `USDP_ZERO4); // [R16]
wire [3:0] rx_len = nbits + {3'h0, fmt_ff[`USDP_FM_PEN]};
assign rx_algn = rxsh_ff >> (4'hA - rx_len);
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rst_ff   <= RX_IDLE;
        rph_ff   <= `USDP_ZERO4;
        rcnt_ff  <= `USDP_ZERO4;
        rxsh_ff  <= 10'h000;
        rxbuf_ff <= 9'h000;
        rxc_ff   <= 1'b0;
        rxd_own  <= 1'b0;
    end
    else
    begin
        rxd_own <= rx_on;
        if (btick && !sync_m)
            rph_ff <= (rph_ff == `USDP_ZERO4) ? ovs_top : rph_ff - `USDP_ONE4;
        if (!rx_on)
        begin
            rst_ff <= RX_IDLE;
            rxc_ff <= 1'b0;                              // [R25]
        end
        else
        begin
            if (rd_data)
                rxc_ff <= 1'b0;
            case (rst_ff)
                RX_IDLE:
                    if (!rx_q_ff)
                    begin
                        rst_ff <= sync_m ? RX_BITS : RX_START; // [R17]
                        rph_ff <= ovs_mid;
                        rcnt_ff <= rx_len;
                    end
                RX_START:
                    if (rx_samp)
                        rst_ff <= rx_q_ff ? RX_IDLE : RX_BITS; // false start
                RX_BITS:
                    if (rx_samp)
                    begin
                        rxsh_ff <= {rx_q_ff, rxsh_ff[9:1]};
                        rcnt_ff <= rcnt_ff - `USDP_ONE4;
                        if (rcnt_ff == `USDP_ZERO4)
                        begin
                            // first stop taken, second never waited for
                            rst_ff   <= RX_IDLE;                // [R18]
                            rxbuf_ff <= rx_algn[8:0] & tx_mask; // [R19] [R20]
                            rxc_ff   <= 1'b1;                   // [R25]
                        end
                    end
                default:
                    rst_ff <= RX_IDLE;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// control registers and read port
// ----------------------------------------------------------------------
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tx_en_ff <= 1'b0;
        rx_en_ff <= 1'b0;
        tx_empty_irq_enable_ff <= 1'b0;
        tx_complete_irq_enable_ff <= 1'b0;
        tx_ninth_bit_ff  <= 1'b0;
        sz2_ff   <= 1'b0;
        u2x_ff   <= 1'b0;
        fmt_ff   <= `USDP_FMT_RST;
        baud_ff  <= `USDP_ZERO12;
        reg_rdata <= `USDP_ZERO8;
        tx_buffer_empty_flag_irq <= 1'b0;
        txc_irq  <= 1'b0;
    end
    else
    begin
        if (wr_ctrl)
        begin
            tx_empty_irq_enable_ff <= reg_wdata[`USDP_CT_TX_EMPTY_IRQ_ENABLE];
            tx_complete_irq_enable_ff <= reg_wdata[`USDP_CT_TX_COMPLETE_IRQ_ENABLE];
            rx_en_ff <= reg_wdata[`USDP_CT_RECEIVER_ENABLE];
            tx_en_ff <= reg_wdata[`USDP_CT_TRANSMITTER_ENABLE];
            sz2_ff   <= reg_wdata[`USDP_CT_SZ2];
            tx_ninth_bit_ff  <= reg_wdata[`USDP_CT_TX_NINTH_BIT];
        end
        if (wr_stat)
            u2x_ff <= reg_wdata[`USDP_ST_U2X];          // empty flag bit is read only
        if (reg_wr && reg_addr == `USDP_ADDR_FMT)
            fmt_ff <= reg_wdata;
        if (reg_wr && reg_addr == `USDP_ADDR_BAUDL)
            baud_ff[7:0] <= reg_wdata;
        if (reg_wr && reg_addr == `USDP_ADDR_BAUDH)
            baud_ff[11:8] <= reg_wdata[3:0];
        tx_buffer_empty_flag_irq <= tx_empty_irq_enable_ff && !txfull_ff;             // [R9]
        txc_irq  <= tx_complete_irq_enable_ff && txc_ff;                 // [R12]
        reg_rdata <= `USDP_ZERO8;
        if (reg_rd)
        begin
            case (reg_addr)
                `USDP_ADDR_DATA:  reg_rdata <= rxbuf_ff[7:0];     // [R28]
                `USDP_ADDR_STAT:  reg_rdata <= {rxc_ff, txc_ff, !txfull_ff,
                                                4'h0, u2x_ff};     // [R8]
                `USDP_ADDR_CTRL:  reg_rdata <= {1'b0, tx_complete_irq_enable_ff, tx_empty_irq_enable_ff, rx_en_ff,
                                                tx_en_ff, sz2_ff, rxbuf_ff[8],
                                                tx_ninth_bit_ff};          // [R26]
                `USDP_ADDR_FMT:   reg_rdata <= fmt_ff;
                `USDP_ADDR_BAUDL: reg_rdata <= baud_ff[7:0];
                `USDP_ADDR_BAUDH: reg_rdata <= {4'h0, baud_ff[11:8]};
                default:          reg_rdata <= `USDP_ZERO8;
            endcase
        end
    end
end

endmodule // usdp_core

// >>> test/usdp_core_checker.sv
/* port checks for usdp_core, bound into each instance.
   assumes one clock and the register map of usdp_defines.vh. */
`include "usdp_defines.vh"
module usdp_core_checker (
    input logic       core_clk,    // clock
    input logic       rst_n,       // reset
    input logic [2:0] reg_addr,    // address
    input logic [7:0] reg_wdata,   // write data
    input logic       reg_wr,      // write
    input logic       reg_rd,      // read
    input logic [7:0] reg_rdata,   // read data
    input logic       txc_irq_ack, // serviced
    input logic       tx_buffer_empty_flag_irq,    // empty irq
    input logic       txc_irq,     // done irq
    input logic       txd_o,       // serial out
    input logic       txd_oe,      // out owned
    input logic       rxd_i,       // serial in
    input logic       rxd_own,     // in owned
    input logic       xck_i,       // clock in
    input logic       xck_o,       // clock out
    input logic       xck_oe       // clock drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_ff; // control shadow
    // ----------------------------------------
    // shadow of control: enables are not on the ports
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_ff <= 8'h00;
        else if (reg_wr && reg_addr == `USDP_ADDR_CTRL)
            ctl_ff <= reg_wdata;
    end
    wire transmitter_enable = ctl_ff[`USDP_CT_TRANSMITTER_ENABLE], receiver_enable = ctl_ff[`USDP_CT_RECEIVER_ENABLE];
    wire tcie = ctl_ff[`USDP_CT_TX_COMPLETE_IRQ_ENABLE], ecie = ctl_ff[`USDP_CT_TX_EMPTY_IRQ_ENABLE];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_tx_owned: assert property (transmitter_enable && $past(transmitter_enable) |-> txd_oe)
        else $error("serial out not owned while enabled");
    a_rx_owned: assert property (receiver_enable == $past(receiver_enable) |-> rxd_own == receiver_enable)
        else $error("serial in ownership differs from enable");
    a_oe_idle_high: assert property ($rose(txd_oe) |-> txd_o)
        else $error("serial out taken at low level");
    a_oe_late_drop: assert property ($fell(txd_oe) |-> !transmitter_enable && $past(txd_o))
        else $error("serial out released mid-frame");
    a_done_at_stop: assert property ($rose(txc_irq) |-> txd_o)
        else $error("complete raised while line low");
    a_done_masked: assert property (!tcie && !$past(tcie) |-> !txc_irq)
        else $error("complete irq while disabled");
    a_empty_masked: assert property (!ecie && !$past(ecie) |-> !tx_buffer_empty_flag_irq)
        else $error("empty irq while disabled");
    a_ack_clears: assert property (txc_irq_ack && txc_irq |-> ##[1:2] !txc_irq)
        else $error("complete irq survives service");
    a_clock_slave: assert property (!xck_oe && !xck_o)
        else $error("sync clock pin driven");
    a_rdata_quiet: assert property (!$past(reg_rd) || $past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00)
        else $error("read data outside a mapped read");
endmodule // usdp_core_checker
bind usdp_core usdp_core_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .txc_irq_ack(txc_irq_ack), .tx_buffer_empty_flag_irq(tx_buffer_empty_flag_irq),
    .txc_irq(txc_irq), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .rxd_own(rxd_own),
    .xck_i(xck_i), .xck_o(xck_o), .xck_oe(xck_oe));

// >>> test/usdp_core_test.sv
/* self-checking bench for usdp_core through its register port.
   assumes a 20 ns clock and divisor 0, so 16 clocks per bit. */
`include "usdp_defines.vh"
module usdp_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] DT = `USDP_ADDR_DATA, ST = `USDP_ADDR_STAT;
    localparam logic [2:0] CT = `USDP_ADDR_CTRL, FM = `USDP_ADDR_FMT;
    logic       core_clk, rst_n, reg_wr, reg_rd, txc_irq_ack, xck_i;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       tx_buffer_empty_flag_irq, txc_irq, txd_o, txd_oe, rxd_i, rxd_own, xck_o, xck_oe;
    int         n_errors = 0, check_count = 0, k;
    usdp_core uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .txc_irq_ack(txc_irq_ack), .tx_buffer_empty_flag_irq(tx_buffer_empty_flag_irq), .txc_irq(txc_irq), .txd_o(txd_o),
        .txd_oe(txd_oe), .rxd_i(rxd_i), .rxd_own(rxd_own), .xck_i(xck_i), .xck_o(xck_o),
        .xck_oe(xck_oe));
    usdp_line_model lm (.core_clk(core_clk), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i));
    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
        check_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // one idle cycle after each write so a strobe is never set twice at one edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk($sformatf("reg%0d", a), reg_rdata, e);
        @(posedge core_clk);
    endtask
    // bounded wait for complete (1) or empty (0) request, sampled at negedge
    task automatic wait_irq(input bit w);
        @(negedge core_clk);
        for (int i = 0; i < 600 && (w ? txc_irq : tx_buffer_empty_flag_irq) !== 1'b1; i++)
            @(negedge core_clk);
        @(posedge core_clk);
    endtask
    task automatic send_chk(input logic [7:0] fm, ct, d, input int nb, input logic [11:0] e);
        wr(FM, fm);
        wr(CT, ct); // ninth bit before data
        lm.nbits = nb;
        k = lm.n_frames;
        wr(DT, d);
        wait_irq(1);
        chk("frame", lm.fr[k], e);
        wr(ST, 8'h40); // empty position written zero
        rdc(ST, 8'h20); // write one clears
    endtask
    task automatic rx_chk(input logic [7:0] fm, ct, input logic [8:0] d, input int nd, ns,
                          input logic [7:0] ec, ed);
        wr(FM, fm);
        wr(CT, ct);
        lm.send(d, nd, ns);
        rdc(ST, 8'hA0); // unread data
        rdc(CT, ec); // ninth read first
        rdc(DT, ed);
        rdc(ST, 8'h20); // read empties
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // whole run is near 2000 cycles; the ceiling leaves ample margin
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_of_test;
    end
    initial
    begin
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        txc_irq_ack = 1'b0;
        xck_i = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdc(FM, 8'h06);
        rdc(ST, 8'h20); // empty after reset
        rdc(3'h6, 8'h00); // unmapped place
        wr(DT, 8'h77);
        chk("txd_oe", txd_oe, 1'b0); // no send while disabled
        wr(`USDP_ADDR_BAUDL, 8'h00); // set up first
        wr(`USDP_ADDR_BAUDH, 8'h00);
        wr(CT, 8'h78);
        wait_irq(0);
        chk("tx_buffer_empty_flag_irq", tx_buffer_empty_flag_irq, 1'b1);
        wr(DT, 8'hA5);
        wait_irq(0);
        wr(DT, 8'h3C);
        rdc(ST, 8'h00); // second char waits
        chk("tx_buffer_empty_flag_irq", tx_buffer_empty_flag_irq, 1'b0);
        wait_irq(1);
        chk("frame0", lm.fr[0], {3'b001, 8'hA5, 1'b0});
        chk("frame1", lm.fr[1], {3'b001, 8'h3C, 1'b0});
        rdc(ST, 8'h60);
        txc_irq_ack <= 1'b1;
        @(posedge core_clk);
        txc_irq_ack <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdc(ST, 8'h20); // serviced
        send_chk(8'h34, 8'h78, 8'hFF, 10, {3'b001, 1'b0, 7'h7F, 1'b0}); // odd
        send_chk(8'h24, 8'h78, 8'h81, 10, {3'b001, 1'b1, 7'h01, 1'b0}); // even
        send_chk(8'h0E, 8'h7D, 8'h55, 12, {3'b111, 8'h55, 1'b0}); // nine bits
        send_chk(8'h00, 8'h78, 8'hEA, 7, {6'h01, 5'h0A, 1'b0}); // five bits
        rx_chk(8'h06, 8'h78, 9'h0C3, 8, 1, 8'h78, 8'hC3);
        rx_chk(8'h08, 8'h78, 9'h01A, 5, 2, 8'h78, 8'h1A); // two stops
        rx_chk(8'h06, 8'h7C, 9'h1AA, 9, 1, 8'h7E, 8'hAA);
        wr(CT, 8'h78);
        lm.send(9'h055, 8, 1);
        wr(CT, 8'h68);
        rdc(ST, 8'h20); // disable flushes
        chk("rxd_own", rxd_own, 1'b0);
        wr(CT, 8'h78);
        lm.nbits = 10;
        k = lm.n_frames;
        wr(DT, 8'h96);
        wr(CT, 8'h70);
        chk("txd_oe", txd_oe, 1'b1); // held while pending
        wait_irq(1);
        chk("frame", lm.fr[k], {3'b001, 8'h96, 1'b0});
        repeat (3) @(posedge core_clk);
        chk("txd_oe", txd_oe, 1'b0); // released when empty
        end_of_test;
    end
endmodule // usdp_core_test

// >>> test/usdp_line_model.sv
/* remote party on the line: decodes serial out, sends on serial in.
   assumes bit_clks core clocks per bit and nbits set by the bench. */
module usdp_line_model (
    input  logic core_clk, // clock
    input  logic txd_o,    // serial out
    input  logic txd_oe,   // out owned
    output logic rxd_i     // serial in
);
    timeunit 1ns;
    timeprecision 1ps;
    int          bit_clks = 16;
    int          nbits    = 10;
    int          n_frames = 0;
    logic [11:0] fr [16];
    initial rxd_i = 1'b1; // idle line is high
    // ----------------------------------------
    // receiver: sampled at negedge so registered outputs have settled
    // ----------------------------------------
    always
    begin
        @(negedge core_clk);
        if (txd_oe === 1'b1 && txd_o === 1'b0)
        begin
            fr[n_frames] = 12'h000;
            repeat (bit_clks / 2) @(negedge core_clk);
            for (int i = 0; i < nbits; i++)
            begin
                fr[n_frames][i] = txd_o;
                if (i < nbits - 1)
                    repeat (bit_clks) @(negedge core_clk);
            end
            n_frames++;
        end
    end
    // sender: start low, data lsb first, high stops, then stays high
    task automatic send(input logic [8:0] d, input int nd, input int ns);
        for (int i = 0; i <= nd + ns; i++)
        begin
            @(posedge core_clk);
            rxd_i <= (i == 0) ? 1'b0 : (i <= nd) ? d[i-1] : 1'b1;
            repeat (bit_clks - 1) @(posedge core_clk);
        end
    endtask
endmodule // usdp_line_model
